//--- rtl/cld_consts.svh
// Constants of the character display instruction decoder
`ifndef CLD_CONSTS_SVH
`define CLD_CONSTS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLD_CLK_MHZ 200
`define CLD_T_CLEAR_NS 1530000
`define CLD_T_CTRL_NS 39000
`define CLD_T_DATA_NS 43000
`define CLD_CNT_W 20
`define CLD_BLINK_BIT 23
// ----------------------------------------------------------------
// Instruction class bits and fields
// ----------------------------------------------------------------
`define CLD_BIT_TEXT_ADR 7
`define CLD_BIT_GLYPH_ADR 6
`define CLD_BIT_FUNC 5
`define CLD_BIT_SHIFT 4
`define CLD_BIT_DISP 3
`define CLD_BIT_ENTRY 2
`define CLD_BIT_HOME 1
`define CLD_BIT_CLEAR 0
`define CLD_F_INC 1
`define CLD_F_SCROLL 0
`define CLD_F_DISP_ON 2
`define CLD_F_CURS_ON 1
`define CLD_F_BLINK_ON 0
`define CLD_F_SC 3
`define CLD_F_RL 2
`define CLD_F_BUSW 4
`define CLD_F_LINES 3
`define CLD_F_FONT 2
// ----------------------------------------------------------------
// Addresses and values
// ----------------------------------------------------------------
`define CLD_SPACE_CODE 8'h20
`define CLD_AC_HOME 7'h00
`define CLD_L1_END 7'h27
`define CLD_L2_BASE 7'h40
`define CLD_L2_END 7'h67
`define CLD_ONE_END 7'h4f
`define CLD_LEN_ONE 7'h50
`define CLD_LEN_TWO 7'h28
`define CLD_TRAM_LAST 7'h7f
`define CLD_RST_BUS8 1'b1
`define CLD_RST_INC 1'b1
`endif

//--- rtl/cld_pkg.sv
// Types of the character display instruction decoder
package cld_pkg;
  typedef enum logic [1:0] {
    CLD_ST_IDLE = 2'b00,
    CLD_ST_FILL = 2'b01,
    CLD_ST_WAIT = 2'b10
  } cld_state_t;
  // Queued transfer: read flag, register select, byte
  typedef logic [9:0] cld_token_t;
endpackage : cld_pkg

//--- rtl/cld_buf2.sv
// Two-entry buffer with valid and ready on both sides
module cld_buf2 #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : cld_buf2

//--- rtl/cld_decoder.sv
// Character display instruction decoder: host bus, executor, text and glyph RAM
`include "cld_consts.svh"
module cld_decoder #(
  parameter int unsigned CLEAR_CYC = (`CLD_T_CLEAR_NS * `CLD_CLK_MHZ + 999) / 1000,
  parameter int unsigned CTRL_CYC = (`CLD_T_CTRL_NS * `CLD_CLK_MHZ + 999) / 1000,
  parameter int unsigned DATA_CYC = (`CLD_T_DATA_NS * `CLD_CLK_MHZ + 999) / 1000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host bus pins
  input wire logic reg_select_i,
  input wire logic rd_not_wr_i,
  input wire logic enable_i,
  input wire logic [7:0] parallel_data_pins_i,
  output logic [7:0] parallel_data_pins_o,
  output logic parallel_data_pins_oe_o,
  // Panel refresh port
  input wire logic [6:0] scan_addr_i,
  output logic [7:0] scan_char_o,
  // Display state
  output logic internal_op_flag_o,
  output logic [6:0] ram_pointer_o,
  output logic glyph_sel_o,
  output logic entry_inc_o,
  output logic auto_scroll_o,
  output logic display_on_o,
  output logic cursor_on_o,
  output logic blink_on_o,
  output logic cursor_solid_o,
  output logic bus_width_sel_o,
  output logic two_line_o,
  output logic tall_font_o,
  output logic [6:0] shift_ofs_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers and strobe edges
  // ----------------------------------------------------------------
  logic [10:0] meta_q, sync_q, sync_d;
  logic e_dly_q, e_dly_d;
  logic e_rise, e_fall, s_rs, s_rw;
  logic [7:0] s_dat;

  always_comb begin
    sync_d = meta_q;
    e_dly_d = sync_q[10];
    {s_rs, s_rw, s_dat} = sync_q[9:0];
    e_rise = sync_q[10] && !e_dly_q;
    e_fall = !sync_q[10] && e_dly_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 11'h000;
      sync_q <= 11'h000;
      e_dly_q <= 1'b0;
    end else begin
      meta_q <= {enable_i, reg_select_i, rd_not_wr_i, parallel_data_pins_i};
      sync_q <= sync_d;
      e_dly_q <= e_dly_d;
    end
  end

  // ----------------------------------------------------------------
  // Memories and executor registers
  // ----------------------------------------------------------------
  logic [7:0] tram [128];
  logic [7:0] gram [64];
  cld_pkg::cld_state_t st_q, st_d;
  logic [`CLD_CNT_W-1:0] cnt_q, cnt_d;
  logic [6:0] ac_q, ac_d, fill_q, fill_d, shift_q, shift_d;
  logic gsel_q, gsel_d, inc_q, inc_d, scroll_q, scroll_d;
  logic disp_q, disp_d, curs_q, curs_d, blink_q, blink_d;
  logic bus8_q, bus8_d, two_q, two_d, tall_q, tall_d;
  logic [`CLD_BLINK_BIT:0] bcnt_q;
  logic [7:0] scan_q;
  logic op_q, op_d;
  logic tram_we, gram_we;
  logic [6:0] tram_wa;
  logic [7:0] tram_wd;

  // Transfers queued for the executor
  logic push_v, push_rdy, tok_v, pop;
  cld_pkg::cld_token_t push_tok, tok;

  cld_buf2 #(
    .W(10)
  ) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push_v),
    .in_ready_o(push_rdy),
    .in_data_i(push_tok),
    .out_valid_o(tok_v),
    .out_ready_i(pop),
    .out_data_o(tok)
  );

  function automatic logic [6:0] step_ac(input logic [6:0] a, input logic inc, input logic two,
                                         input logic glyph);
    logic [6:0] r;
    r = inc ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (glyph) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (inc && a == `CLD_L1_END) r = `CLD_L2_BASE;
      else if (inc && a == `CLD_L2_END) r = `CLD_AC_HOME;
      else if (!inc && a == `CLD_L2_BASE) r = `CLD_L1_END;
      else if (!inc && a == `CLD_AC_HOME) r = `CLD_L2_END;
    end else begin
      if (inc && a == `CLD_ONE_END) r = `CLD_AC_HOME;
      else if (!inc && a == `CLD_AC_HOME) r = `CLD_ONE_END;
    end
    return r;
  endfunction : step_ac

  // Offset wraps at the line length so each line scrolls on its own
  function automatic logic [6:0] step_shift(input logic [6:0] s, input logic left, input logic two);
    logic [6:0] last;
    last = two ? 7'(`CLD_LEN_TWO - 7'h01) : 7'(`CLD_LEN_ONE - 7'h01);
    if (left) return (s >= last) ? 7'h00 : 7'(s + 7'h01);
    return (s == 7'h00) ? last : 7'(s - 7'h01);
  endfunction : step_shift

  // ----------------------------------------------------------------
  // Host side: nibble pairing, read data, transfer capture
  // ----------------------------------------------------------------
  logic nib_q, nib_d;
  logic [3:0] hi_q, hi_d;
  logic [7:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic busy;
  logic [7:0] rd_word;

  always_comb begin
    // Queued work counts as busy, so the host never overruns the buffer
    busy = (st_q != cld_pkg::CLD_ST_IDLE) || tok_v;
    rd_word = s_rs ? (gsel_q ? gram[ac_q[5:0]] : tram[ac_q]) : {busy, ac_q};
    nib_d = nib_q;
    hi_d = hi_q;
    dout_d = dout_q;
    oe_d = oe_q;
    push_v = 1'b0;
    push_tok = {s_rw, s_rs, s_dat};
    if (e_rise && s_rw) begin
      oe_d = 1'b1;
      dout_d = (bus8_q || !nib_q) ? rd_word : {rd_word[3:0], 4'h0};
    end
    if (e_fall) begin
      oe_d = 1'b0;
      if (bus8_q) begin
        push_v = !s_rw || s_rs;
      end else if (!nib_q) begin
        nib_d = 1'b1;
        hi_d = s_dat[7:4];
      end else begin
        nib_d = 1'b0;
        push_v = !s_rw || s_rs;
        push_tok = {s_rw, s_rs, hi_q, s_dat[7:4]};
      end
    end
    // A transfer arriving while both entries are taken breaks the busy handshake and is dropped
    push_v = push_v && push_rdy;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nib_q <= 1'b0;
      hi_q <= 4'h0;
      dout_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      nib_q <= nib_d;
      hi_q <= hi_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Executor
  // ----------------------------------------------------------------
  logic t_rw, t_rs;
  logic [7:0] t_d;

  always_comb begin
    {t_rw, t_rs, t_d} = tok;
    st_d = st_q;
    cnt_d = cnt_q;
    ac_d = ac_q;
    fill_d = fill_q;
    shift_d = shift_q;
    gsel_d = gsel_q;
    inc_d = inc_q;
    scroll_d = scroll_q;
    disp_d = disp_q;
    curs_d = curs_q;
    blink_d = blink_q;
    bus8_d = bus8_q;
    two_d = two_q;
    tall_d = tall_q;
    pop = 1'b0;
    tram_we = 1'b0;
    tram_wa = ac_q;
    tram_wd = t_d;
    gram_we = 1'b0;
    case (st_q)
      cld_pkg::CLD_ST_FILL: begin
        tram_we = 1'b1;
        tram_wa = fill_q;
        tram_wd = `CLD_SPACE_CODE;
        fill_d = 7'(fill_q + 7'h01);
        cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - `CLD_CNT_W'(1);
        if (fill_q == `CLD_TRAM_LAST) st_d = cld_pkg::CLD_ST_WAIT;
      end
      cld_pkg::CLD_ST_WAIT: begin
        if (cnt_q <= `CLD_CNT_W'(1)) st_d = cld_pkg::CLD_ST_IDLE;
        else cnt_d = cnt_q - `CLD_CNT_W'(1);
      end
      default: begin
        if (tok_v) begin
          pop = 1'b1;
          st_d = cld_pkg::CLD_ST_WAIT;
          cnt_d = `CLD_CNT_W'(CTRL_CYC);
          if (t_rs) begin
            cnt_d = `CLD_CNT_W'(DATA_CYC);
            ac_d = step_ac(ac_q, inc_q, two_q, gsel_q);
            if (!t_rw) begin
              tram_we = !gsel_q;
              gram_we = gsel_q;
              if (scroll_q && !gsel_q) shift_d = step_shift(shift_q, inc_q, two_q);
            end
          end else if (t_d[`CLD_BIT_TEXT_ADR]) begin
            ac_d = t_d[6:0];
            gsel_d = 1'b0;
          end else if (t_d[`CLD_BIT_GLYPH_ADR]) begin
            ac_d = {1'b0, t_d[5:0]};
            gsel_d = 1'b1;
          end else if (t_d[`CLD_BIT_FUNC]) begin
            bus8_d = t_d[`CLD_F_BUSW];
            two_d = t_d[`CLD_F_LINES];
            tall_d = t_d[`CLD_F_FONT];
            if (t_d[`CLD_F_LINES] != two_q) shift_d = 7'h00;
          end else if (t_d[`CLD_BIT_SHIFT]) begin
            if (t_d[`CLD_F_SC]) shift_d = step_shift(shift_q, !t_d[`CLD_F_RL], two_q);
            else ac_d = step_ac(ac_q, t_d[`CLD_F_RL], two_q, gsel_q);
          end else if (t_d[`CLD_BIT_DISP]) begin
            disp_d = t_d[`CLD_F_DISP_ON];
            curs_d = t_d[`CLD_F_CURS_ON];
            blink_d = t_d[`CLD_F_BLINK_ON];
          end else if (t_d[`CLD_BIT_ENTRY]) begin
            inc_d = t_d[`CLD_F_INC];
            scroll_d = t_d[`CLD_F_SCROLL];
          end else if (t_d[`CLD_BIT_HOME]) begin
            ac_d = `CLD_AC_HOME;
            gsel_d = 1'b0;
            shift_d = 7'h00;
            cnt_d = `CLD_CNT_W'(CLEAR_CYC);
          end else if (t_d[`CLD_BIT_CLEAR]) begin
            ac_d = `CLD_AC_HOME;
            gsel_d = 1'b0;
            inc_d = 1'b1;
            shift_d = 7'h00;
            fill_d = 7'h00;
            cnt_d = `CLD_CNT_W'(CLEAR_CYC);
            st_d = cld_pkg::CLD_ST_FILL;
          end else begin
            st_d = cld_pkg::CLD_ST_IDLE;
          end
        end
      end
    endcase
    // Busy pin is registered from the next state, so it tracks the executor without lag
    op_d = (st_d != cld_pkg::CLD_ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= cld_pkg::CLD_ST_IDLE;
      cnt_q <= '0;
      ac_q <= `CLD_AC_HOME;
      fill_q <= 7'h00;
      shift_q <= 7'h00;
      gsel_q <= 1'b0;
      inc_q <= `CLD_RST_INC;
      scroll_q <= 1'b0;
      disp_q <= 1'b0;
      curs_q <= 1'b0;
      blink_q <= 1'b0;
      bus8_q <= `CLD_RST_BUS8;
      two_q <= 1'b0;
      tall_q <= 1'b0;
      bcnt_q <= '0;
      scan_q <= 8'h00;
      op_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ac_q <= ac_d;
      fill_q <= fill_d;
      shift_q <= shift_d;
      gsel_q <= gsel_d;
      inc_q <= inc_d;
      scroll_q <= scroll_d;
      disp_q <= disp_d;
      curs_q <= curs_d;
      blink_q <= blink_d;
      bus8_q <= bus8_d;
      two_q <= two_d;
      tall_q <= tall_d;
      bcnt_q <= bcnt_q + 1'b1;
      scan_q <= tram[scan_addr_i];
      op_q <= op_d;
    end
  end

  // RAM contents are undefined after power-up, as on the real panel
  always_ff @(posedge clk_i) begin
    if (tram_we) tram[tram_wa] <= tram_wd;
    if (gram_we) gram[ac_q[5:0]] <= t_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic solid_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) solid_q <= 1'b0;
    else solid_q <= blink_d && bcnt_q[`CLD_BLINK_BIT];
  end

  assign parallel_data_pins_o = dout_q;
  assign parallel_data_pins_oe_o = oe_q;
  assign scan_char_o = scan_q;
  assign internal_op_flag_o = op_q;
  assign ram_pointer_o = ac_q;
  assign glyph_sel_o = gsel_q;
  assign entry_inc_o = inc_q;
  assign auto_scroll_o = scroll_q;
  assign display_on_o = disp_q;
  assign cursor_on_o = curs_q;
  assign blink_on_o = blink_q;
  assign cursor_solid_o = solid_q;
  assign bus_width_sel_o = bus8_q;
  assign two_line_o = two_q;
  assign tall_font_o = tall_q;
  assign shift_ofs_o = shift_q;
endmodule : cld_decoder

//--- bench/cld_decoder_asserts.sv
// Port checker of the display instruction decoder
module cld_decoder_asserts #(
  parameter int unsigned CTRL_CYC = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Host bus
  input wire logic enable_i,
  input wire logic rd_not_wr_i,
  input wire logic [7:0] parallel_data_pins_o,
  input wire logic parallel_data_pins_oe_o,
  // Display state
  input wire logic internal_op_flag_o,
  input wire logic [6:0] ram_pointer_o,
  input wire logic glyph_sel_o,
  input wire logic blink_on_o,
  input wire logic cursor_solid_o,
  input wire logic [6:0] shift_ofs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Busy length counter, too long for a repetition
  // ----------------------------------------------------------------
  logic [10:0] busy_cnt_q;
  logic [10:0] busy_cnt_d;
  always_comb begin
    busy_cnt_d = internal_op_flag_o ? busy_cnt_q + 11'h001 : 11'h000;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_q <= 11'h000;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  sequence s_read_held;
    (enable_i && rd_not_wr_i) [*5];
  endsequence
  sequence s_bus_idle;
    (!enable_i) [*5];
  endsequence
  property p_busy_min;
    $fell(internal_op_flag_o) |-> busy_cnt_q >= CTRL_CYC - 2;
  endproperty
  property p_busy_max;
    busy_cnt_q <= 11'h3e8;
  endproperty
  property p_read_answer;
    s_read_held |-> parallel_data_pins_oe_o;
  endproperty
  property p_bus_idle;
    s_bus_idle |-> !parallel_data_pins_oe_o;
  endproperty
  property p_read_hold;
    parallel_data_pins_oe_o && $past(parallel_data_pins_oe_o) |-> $stable(parallel_data_pins_o);
  endproperty
  property p_solid_blink;
    cursor_solid_o |-> blink_on_o;
  endproperty
  property p_ofs_range;
    shift_ofs_o <= 7'h4f;
  endproperty
  property p_glyph_ptr;
    glyph_sel_o |-> !ram_pointer_o[6];
  endproperty
  property p_ptr_busy;
    $changed(ram_pointer_o) |-> ##[0:2] internal_op_flag_o;
  endproperty
  property p_ofs_busy;
    $changed(shift_ofs_o) |-> ##[0:2] internal_op_flag_o;
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy period too short");
  a_busy_max: assert property (p_busy_max) else $error("busy period too long");
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_bus_idle: assert property (p_bus_idle) else $error("pins driven while idle");
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
  a_solid_blink: assert property (p_solid_blink) else $error("solid cursor without blink");
  a_ofs_range: assert property (p_ofs_range) else $error("shift offset out of range");
  a_glyph_ptr: assert property (p_glyph_ptr) else $error("glyph address too wide");
  a_ptr_busy: assert property (p_ptr_busy) else $error("pointer moved while idle");
  a_ofs_busy: assert property (p_ofs_busy) else $error("display shifted while idle");
endmodule : cld_decoder_asserts

bind cld_decoder cld_decoder_asserts #(.CTRL_CYC(CTRL_CYC)) i_asserts (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i), .rd_not_wr_i(rd_not_wr_i),
  .parallel_data_pins_o(parallel_data_pins_o), .parallel_data_pins_oe_o(parallel_data_pins_oe_o),
  .internal_op_flag_o(internal_op_flag_o), .ram_pointer_o(ram_pointer_o), .glyph_sel_o(glyph_sel_o),
  .blink_on_o(blink_on_o), .cursor_solid_o(cursor_solid_o), .shift_ofs_o(shift_ofs_o));

//--- bench/cld_host_model.sv
// Host processor model on the display bus
module cld_host_model (
  // Clock
  input wire logic clk_i,
  // Bus towards the device
  output logic reg_select_o,
  output logic rd_not_wr_o,
  output logic enable_o,
  output logic [7:0] line_o,
  // Device drive
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] last_q = 8'h00;
  initial begin
    reg_select_o = 1'b0;
    rd_not_wr_o = 1'b0;
    enable_o = 1'b0;
  end
  // Released lines keep no level: show a changing pattern
  assign line_o = dev_oe_i ? dev_data_i : (drv ? wdata : ~last_q);
  always @(posedge clk_i) begin
    last_q <= line_o;
  end
  task automatic pulse(input logic [1:0] k, input logic [7:0] v, output logic [7:0] r);
    @(negedge clk_i);
    {reg_select_o, rd_not_wr_o} = k;
    wdata = v;
    drv = !k[0];
    @(negedge clk_i);
    enable_o = 1'b1;
    repeat (6) @(negedge clk_i);
    r = line_o;
    enable_o = 1'b0;
    repeat (4) @(negedge clk_i);
    drv = 1'b0;
  endtask : pulse
  task automatic xfer(input logic [1:0] k, input logic [7:0] v, input logic nib, output logic [7:0] r);
    logic [7:0] hi;
    if (nib) begin
      pulse(k, {v[7:4], ~v[7:4]}, hi);
      pulse(k, {v[3:0], ~v[3:0]}, r);
      r = {hi[7:4], r[7:4]};
    end else begin
      pulse(k, v, r);
    end
  endtask : xfer
endmodule : cld_host_model

//--- bench/cld_decoder_tb_top.sv
// Self-checking bench of the display instruction decoder
module cld_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rs, rw, en, oe, busy, gsel, inc, scr, don, con, bon, w8, two, tall, solid;
  logic [7:0] line, dout, sc;
  logic [6:0] ptr, ofs;
  logic [6:0] saddr = 7'h00;
  logic nib = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  cld_host_model i_host (.clk_i(clk), .reg_select_o(rs), .rd_not_wr_o(rw), .enable_o(en),
    .line_o(line), .dev_data_i(dout), .dev_oe_i(oe));
  // Short counts keep the run brief; the long data count lets the buffer fill
  cld_decoder #(.CLEAR_CYC(300), .CTRL_CYC(20), .DATA_CYC(200)) i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .reg_select_i(rs), .rd_not_wr_i(rw), .enable_i(en),
    .parallel_data_pins_i(line), .parallel_data_pins_o(dout), .parallel_data_pins_oe_o(oe),
    .scan_addr_i(saddr), .scan_char_o(sc), .internal_op_flag_o(busy), .ram_pointer_o(ptr),
    .glyph_sel_o(gsel), .entry_inc_o(inc), .auto_scroll_o(scr), .display_on_o(don),
    .cursor_on_o(con), .blink_on_o(bon), .cursor_solid_o(solid), .bus_width_sel_o(w8),
    .two_line_o(two), .tall_font_o(tall), .shift_ofs_o(ofs));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_idle();
    logic [7:0] st;
    st = 8'h80;
    for (int i = 0; i < 100 && st[7] !== 1'b0; i++) begin
      i_host.xfer(2'h1, 8'h00, nib, st);
    end
    chk("busy flag", 8'h00, {st[7], 7'h00});
  endtask : wait_idle
  task automatic op(input logic [1:0] k, input logic [7:0] v, output logic [7:0] r);
    i_host.xfer(k, v, nib, r);
    wait_idle();
  endtask : op
  task automatic scan(input logic [6:0] a, output logic [7:0] c);
    @(negedge clk);
    saddr = a;
    repeat (2) @(negedge clk);
    c = sc;
  endtask : scan
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_clear();
    logic [7:0] r;
    op(2'h0, 8'h04, r);
    op(2'h0, 8'h95, r);
    i_host.xfer(2'h0, 8'h01, nib, r);
    i_host.xfer(2'h1, 8'h00, nib, r);
    chk("busy after clear", 8'h80, r & 8'h80);
    chk("busy pin", 8'h01, {7'h00, busy});
    wait_idle();
    chk("busy pin idle", 8'h00, {7'h00, busy});
    chk("pointer", 8'h00, {1'b0, ptr});
    chk("entry inc", 8'h01, {7'h00, inc});
    // Still one-line mode here: stepping left from zero lands on the last cell
    op(2'h0, 8'h10, r);
    chk("one line wrap", 8'h4f, {1'b0, ptr});
    for (int a = 0; a < 128; a += 63) begin
      scan(7'(a), r);
      chk("cleared cell", 8'h20, r);
    end
  endtask : t_clear
  task automatic t_modes();
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      op(2'h0, 8'h04 | 8'(i), r);
      chk("entry mode", 8'(i), {6'h00, inc, scr});
    end
    for (int i = 0; i < 8; i++) begin
      op(2'h0, 8'h08 | 8'(i), r);
      chk("display ctrl", 8'(i), {5'h00, don, con, bon});
      if (i % 2 == 0) begin
        chk("solid cursor", 8'h00, {7'h00, solid});
      end
    end
    chk("entry kept", 8'h01, {7'h00, inc});
    for (int i = 0; i < 4; i++) begin
      op(2'h0, 8'h33 | 8'(i << 2), r);
      chk("function set", 8'(4 | i), {5'h00, w8, two, tall});
    end
  endtask : t_modes
  task automatic t_text();
    logic [7:0] r;
    op(2'h0, 8'h06, r);
    op(2'h0, 8'ha7, r);
    op(2'h2, 8'h41, r);
    chk("pointer wrap", 8'h40, {1'b0, ptr});
    op(2'h0, 8'ha7, r);
    op(2'h3, 8'h00, r);
    chk("read data", 8'h41, r);
    chk("pointer after read", 8'h40, {1'b0, ptr});
  endtask : t_text
  task automatic t_scroll();
    logic [7:0] r;
    logic [7:0] code [4] = '{8'h14, 8'h10, 8'h18, 8'h1c};
    logic [7:0] eptr [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] eofs [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
    op(2'h0, 8'h03, r);
    chk("home pointer", 8'h00, {1'b0, ptr});
    scan(7'h27, r);
    chk("home keeps ram", 8'h41, r);
    op(2'h0, 8'h07, r);
    op(2'h2, 8'h42, r);
    chk("scroll left", 8'h01, {1'b0, ofs});
    op(2'h0, 8'h80, r);
    op(2'h3, 8'h00, r);
    chk("no scroll on read", 8'h01, {1'b0, ofs});
    op(2'h0, 8'h05, r);
    op(2'h2, 8'h43, r);
    chk("scroll right", 8'h00, {1'b0, ofs});
    chk("pointer down", 8'h00, {1'b0, ptr});
    for (int i = 0; i < 4; i++) begin
      op(2'h0, code[i], r);
      chk("shift pointer", eptr[i], {1'b0, ptr});
      chk("shift offset", eofs[i], {1'b0, ofs});
    end
  endtask : t_scroll
  task automatic t_glyph();
    logic [7:0] r;
    op(2'h0, 8'h07, r);
    op(2'h0, 8'h7f, r);
    chk("glyph select", 8'h01, {7'h00, gsel});
    chk("glyph address", 8'h3f, {1'b0, ptr});
    op(2'h2, 8'h1f, r);
    chk("glyph step", 8'h00, {1'b0, ptr});
    chk("no glyph scroll", 8'h00, {1'b0, ofs});
    op(2'h0, 8'h7f, r);
    op(2'h3, 8'h00, r);
    chk("glyph read", 8'h1f, r);
    op(2'h0, 8'h80, r);
    chk("text select", 8'h00, {7'h00, gsel});
    op(2'h0, 8'h06, r);
  endtask : t_glyph
  task automatic t_fill();
    logic [7:0] r;
    op(2'h0, 8'h90, r);
    // Executor stalls on the first write while two queue and the fourth is lost
    for (int i = 0; i < 4; i++) begin
      i_host.xfer(2'h2, 8'h61 + 8'(i), nib, r);
    end
    wait_idle();
    chk("pointer after fill", 8'h13, {1'b0, ptr});
    scan(7'h12, r);
    chk("queued write", 8'h63, r);
    scan(7'h13, r);
    chk("dropped write", 8'h20, r);
  endtask : t_fill
  task automatic t_nibble();
    logic [7:0] r;
    // The new width holds once the function set has run, so polling already pairs nibbles
    i_host.xfer(2'h0, 8'h2c, nib, r);
    nib = 1'b1;
    wait_idle();
    chk("narrow bus", 8'h00, {7'h00, w8});
    op(2'h0, 8'h95, r);
    op(2'h2, 8'h5a, r);
    op(2'h0, 8'h95, r);
    op(2'h3, 8'h00, r);
    chk("nibble read", 8'h5a, r);
    i_host.xfer(2'h0, 8'h3c, nib, r);
    nib = 1'b0;
    wait_idle();
    chk("wide bus", 8'h01, {7'h00, w8});
  endtask : t_nibble
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_clear();
    t_modes();
    t_text();
    t_scroll();
    t_glyph();
    t_fill();
    t_nibble();
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("unexpected watchdog: expected done, seen timeout");
    end_of_test();
  end
endmodule : cld_decoder_tb_top
